/* hw/dac_serial_defines.vh */
`ifndef DAC_SERIAL_DEFINES_VH
`define DAC_SERIAL_DEFINES_VH

// ------------------------------------------------------------
// clock and timing
// ------------------------------------------------------------
`define CLK_FREQ_KHZ 250000
`define IDLE_TIME_MS 100
`define CAL_TIME_MS 300

// ------------------------------------------------------------
// instruction byte fields
// ------------------------------------------------------------
`define INS_DIR_BIT 7
`define INS_LEN_HI 6
`define INS_LEN_LO 5
`define INS_ADDR_HI 3
`define INS_ADDR_LO 0

// ------------------------------------------------------------
// byte addresses
// ------------------------------------------------------------
`define ADDR_DATA_B2 4'h0
`define ADDR_DATA_B1 4'h1
`define ADDR_DATA_B0 4'h2
`define ADDR_CMD_B1 4'h4
`define ADDR_CMD_B0 4'h5
`define ADDR_OCAL_B2 4'h8
`define ADDR_OCAL_B1 4'h9
`define ADDR_OCAL_B0 4'ha
`define ADDR_FCAL_B2 4'hc
`define ADDR_FCAL_B1 4'hd
`define ADDR_FCAL_B0 4'he

// ------------------------------------------------------------
// command_control fields and defaults
// ------------------------------------------------------------
`define CMD_ADAPTIVE_FILTER_DISABLE 15
`define CMD_CAL_OUTPUT_CONNECT 14
`define CMD_SH 13
`define CMD_CALIBRATION_RESET 9
`define CMD_RES 7
`define CMD_CLR 6
`define CMD_DF 5
`define CMD_FAST_SETTLE_DISABLE 4
`define CMD_BD 3
`define CMD_BITORD 2
`define CMD_MD_HI 1
`define CMD_MD_LO 0
`define CMD_FIX_MASK 16'h1d00
`define CMD_FIX_VAL 16'h0800
`define CMD_RESET 16'h0802
`define MODE_NORMAL 2'h0
`define MODE_SELFCAL 2'h1
`define MODE_SLEEP 2'h2
`define DATA_RESET 24'h000000
`define CAL_RESET 24'h000000

`endif

/* hw/dac_serial_register_control.v */
`timescale 1ns/10ps
`include "dac_serial_defines.vh"

module dac_serial_register_control #(
  parameter [31:0] IDLE_CYCLES = `IDLE_TIME_MS * `CLK_FREQ_KHZ,
  parameter [31:0] CAL_CYCLES = `CAL_TIME_MS * `CLK_FREQ_KHZ
) (
  input wire clk,
  input wire nrst,
  input wire sclk,
  input wire cs_n,
  input wire sdio_in,
  output reg sdio_out,
  output reg sdio_oe,
  input wire [23:0] cal_offset_result,
  input wire [23:0] cal_gain_result,
  output reg [19:0] mod_code,
  output reg mod_load,
  output reg res_20bit,
  output reg fast_settle_adaptive,
  output reg fast_settle_forced,
  output reg sh_connect,
  output reg output_enable,
  output reg cal_active,
  output reg sleep_active,
  output reg iface_timeout
);

  // ------------------------------------------------------------
  // local encodings
  // ------------------------------------------------------------
  localparam [2:0] CTL_POR = 3'h1;
  localparam [2:0] CTL_CAL = 3'h2;
  localparam [2:0] CTL_NORM = 3'h4;
  localparam [1:0] SER_INSTR = 2'h1;
  localparam [1:0] SER_DATA = 2'h2;

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  // live byte seen at a byte address; reserved holes read zero
  function [7:0] byte_at;
    input [3:0] a;
    input [23:0] d;
    input [15:0] c;
    input [23:0] o;
    input [23:0] f;
    begin
      case (a)
        `ADDR_DATA_B2: byte_at = d[23:16];
        `ADDR_DATA_B1: byte_at = d[15:8];
        `ADDR_DATA_B0: byte_at = d[7:0];
        `ADDR_CMD_B1: byte_at = c[15:8];
        `ADDR_CMD_B0: byte_at = c[7:0];
        `ADDR_OCAL_B2: byte_at = o[23:16];
        `ADDR_OCAL_B1: byte_at = o[15:8];
        `ADDR_OCAL_B0: byte_at = o[7:0];
        `ADDR_FCAL_B2: byte_at = f[23:16];
        `ADDR_FCAL_B1: byte_at = f[15:8];
        `ADDR_FCAL_B0: byte_at = f[7:0];
        default: byte_at = 8'h00;
      endcase
    end
  endfunction

  // index of the bit that goes on the wire for a given bit count
  function [2:0] wire_bit;
    input [2:0] cnt;
    input lsb_first;
    begin
      wire_bit = lsb_first ? cnt : (3'h7 - cnt);
    end
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers and edge detect
  // ------------------------------------------------------------
  reg sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
  reg cs_s1_reg, cs_s2_reg;
  reg sdio_s1_reg, sdio_s2_reg;
  wire sclk_rise = sclk_s2_reg & ~sclk_s3_reg;
  wire sclk_fall = ~sclk_s2_reg & sclk_s3_reg;
  wire sel = ~cs_s2_reg;

  // two flops per pin; the third sclk stage only feeds the edge detect
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_s3_reg <= 1'b0;
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      sdio_s1_reg <= 1'b0;
      sdio_s2_reg <= 1'b0;
    end else begin
      sclk_s1_reg <= sclk;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      cs_s1_reg <= cs_n;
      cs_s2_reg <= cs_s1_reg;
      sdio_s1_reg <= sdio_in;
      sdio_s2_reg <= sdio_s1_reg;
    end
  end

  // ------------------------------------------------------------
  // register bank and serial state
  // ------------------------------------------------------------
  // register widths
  reg [23:0] data_input_value_reg;
  reg [15:0] command_control_reg;
  reg [23:0] offset_calibration_reg;
  reg [23:0] full_scale_calibration_reg;
  reg [2:0] ctl_reg;
  reg [31:0] cal_cnt_reg;
  reg [1:0] ser_reg;
  reg [2:0] bit_cnt_reg;
  reg [7:0] rx_reg;
  reg [7:0] instruction_byte_reg;
  reg [3:0] addr_reg;
  reg [1:0] byte_cnt_reg;
  reg [7:0] tx_reg;
  reg [31:0] idle_cnt_reg;
  reg [23:0] sh_data_reg, sh_ocal_reg, sh_fcal_reg;
  reg [15:0] sh_cmd_reg;
  reg [3:0] touch_reg;

  wire byte_order = command_control_reg[`CMD_BD];
  wire lsb_first = command_control_reg[`CMD_BITORD];
  wire [1:0] op_mode = {command_control_reg[`CMD_MD_HI], command_control_reg[`CMD_MD_LO]};
  wire is_read = instruction_byte_reg[`INS_DIR_BIT];
  wire [1:0] len_code = {instruction_byte_reg[`INS_LEN_HI], instruction_byte_reg[`INS_LEN_LO]};

  // ------------------------------------------------------------
  // byte assembly and write staging
  // ------------------------------------------------------------
  reg [7:0] rx_next;
  reg byte_done;
  reg last_byte;
  reg [3:0] addr_step;
  reg [23:0] sh_data_next, sh_ocal_next, sh_fcal_next;
  reg [15:0] sh_cmd_next;
  reg [3:0] touch_next;
  reg write_cmd_group;

  // incoming bit joins the byte from the chosen end
  always @* begin
    rx_next = rx_reg;
    byte_done = 1'b0;
    last_byte = 1'b0;
    sh_data_next = sh_data_reg;
    sh_cmd_next = sh_cmd_reg;
    sh_ocal_next = sh_ocal_reg;
    sh_fcal_next = sh_fcal_reg;
    touch_next = touch_reg;
    if (sel && sclk_fall) begin
      rx_next = lsb_first ? {sdio_s2_reg, rx_reg[7:1]} : {rx_reg[6:0], sdio_s2_reg};
      byte_done = (bit_cnt_reg == 3'h7);
    end
    last_byte = byte_done && (ser_reg == SER_DATA) && (byte_cnt_reg == len_code);
    if (byte_done && ser_reg == SER_DATA && !is_read) begin
      case (addr_reg)
        `ADDR_DATA_B2: sh_data_next[23:16] = rx_next;
        `ADDR_DATA_B1: sh_data_next[15:8] = rx_next;
        `ADDR_DATA_B0: sh_data_next[7:0] = rx_next;
        `ADDR_CMD_B1: sh_cmd_next[15:8] = rx_next;
        `ADDR_CMD_B0: sh_cmd_next[7:0] = rx_next;
        `ADDR_OCAL_B2: sh_ocal_next[23:16] = rx_next;
        `ADDR_OCAL_B1: sh_ocal_next[15:8] = rx_next;
        `ADDR_OCAL_B0: sh_ocal_next[7:0] = rx_next;
        `ADDR_FCAL_B2: sh_fcal_next[23:16] = rx_next;
        `ADDR_FCAL_B1: sh_fcal_next[15:8] = rx_next;
        `ADDR_FCAL_B0: sh_fcal_next[7:0] = rx_next;
        default: touch_next = touch_reg;
      endcase
      touch_next = touch_reg | {addr_reg[3:2] == 2'h3, addr_reg[3:2] == 2'h2,
                                addr_reg[3:2] == 2'h1, addr_reg[3:2] == 2'h0};
    end
    write_cmd_group = !is_read && (addr_reg[3:2] == 2'h1);
    addr_step = (byte_order && !write_cmd_group) ? (addr_reg - 4'h1) : (addr_reg + 4'h1);
  end

  // ------------------------------------------------------------
  // serial interface sequencer
  // ------------------------------------------------------------
  wire idle_hit = (ser_reg == SER_DATA || bit_cnt_reg != 3'h0) &&
                  (idle_cnt_reg == IDLE_CYCLES - 32'h1);

  // the shadows let a multi-byte write land whole at its final bit
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ser_reg <= SER_INSTR;
      bit_cnt_reg <= 3'h0;
      rx_reg <= 8'h00;
      instruction_byte_reg <= 8'h00;
      addr_reg <= 4'h0;
      byte_cnt_reg <= 2'h0;
      tx_reg <= 8'h00;
      idle_cnt_reg <= 32'h0;
      sh_data_reg <= `DATA_RESET;
      sh_cmd_reg <= `CMD_RESET;
      sh_ocal_reg <= `CAL_RESET;
      sh_fcal_reg <= `CAL_RESET;
      touch_reg <= 4'h0;
      sdio_out <= 1'b0;
      sdio_oe <= 1'b0;
      iface_timeout <= 1'b0;
    end else begin
      iface_timeout <= 1'b0;
      rx_reg <= rx_next;
      sh_data_reg <= sh_data_next;
      sh_cmd_reg <= sh_cmd_next;
      sh_ocal_reg <= sh_ocal_next;
      sh_fcal_reg <= sh_fcal_next;
      touch_reg <= touch_next;
      if (sel && (sclk_rise || sclk_fall))
        idle_cnt_reg <= 32'h0;
      else if (!idle_hit)
        idle_cnt_reg <= idle_cnt_reg + 32'h1;
      if (idle_hit) begin
        ser_reg <= SER_INSTR;
        bit_cnt_reg <= 3'h0;
        sdio_oe <= 1'b0;
        touch_reg <= 4'h0;
        idle_cnt_reg <= 32'h0;
        iface_timeout <= 1'b1;
      end else begin
        // read bit out on rising edge
        if (sel && sclk_rise && ser_reg == SER_DATA && is_read)
          sdio_out <= tx_reg[wire_bit(bit_cnt_reg, lsb_first)];
        if (sel && sclk_fall)
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
        case (ser_reg)
          SER_INSTR: begin
            if (byte_done) begin
              instruction_byte_reg <= rx_next;
              addr_reg <= rx_next[`INS_ADDR_HI:`INS_ADDR_LO];
              byte_cnt_reg <= 2'h0;
              ser_reg <= SER_DATA;
              touch_reg <= 4'h0;
              sh_data_reg <= data_input_value_reg;
              sh_cmd_reg <= command_control_reg;
              sh_ocal_reg <= offset_calibration_reg;
              sh_fcal_reg <= full_scale_calibration_reg;
              sdio_oe <= rx_next[`INS_DIR_BIT];
              tx_reg <= byte_at(rx_next[`INS_ADDR_HI:`INS_ADDR_LO], data_input_value_reg,
                                command_control_reg, offset_calibration_reg,
                                full_scale_calibration_reg);
            end
          end
          SER_DATA: begin
            if (byte_done) begin
              // command read steps down with byte_order
              addr_reg <= addr_step;
              byte_cnt_reg <= byte_cnt_reg + 2'h1;
              tx_reg <= byte_at(addr_step, data_input_value_reg, command_control_reg,
                                offset_calibration_reg, full_scale_calibration_reg);
              if (last_byte) begin
                ser_reg <= SER_INSTR;
                sdio_oe <= 1'b0;
              end
            end
          end
          default: ser_reg <= SER_INSTR;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // internal controller and live registers
  // ------------------------------------------------------------
  wire commit = last_byte && !is_read && !idle_hit;
  // fixed bits forced whatever the host sends
  wire [15:0] cmd_new = (sh_cmd_next & ~`CMD_FIX_MASK) | `CMD_FIX_VAL;
  wire [1:0] mode_new = {cmd_new[`CMD_MD_HI], cmd_new[`CMD_MD_LO]};

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl_reg <= CTL_POR;
      cal_cnt_reg <= 32'h0;
      command_control_reg <= `CMD_RESET;
      data_input_value_reg <= `DATA_RESET;
      offset_calibration_reg <= `CAL_RESET;
      full_scale_calibration_reg <= `CAL_RESET;
      mod_load <= 1'b0;
    end else begin
      mod_load <= 1'b0;
      case (ctl_reg)
        CTL_POR: begin
          command_control_reg <= `CMD_RESET;
          data_input_value_reg <= `DATA_RESET;
          offset_calibration_reg <= `CAL_RESET;
          full_scale_calibration_reg <= `CAL_RESET;
          ctl_reg <= CTL_NORM;
        end
        CTL_CAL: begin
          // writes blocked, mode back to normal at end
          cal_cnt_reg <= cal_cnt_reg + 32'h1;
          if (cal_cnt_reg == CAL_CYCLES - 32'h1) begin
            offset_calibration_reg <= cal_offset_result;
            full_scale_calibration_reg <= cal_gain_result;
            command_control_reg[`CMD_MD_HI] <= 1'b0;
            command_control_reg[`CMD_MD_LO] <= 1'b0;
            ctl_reg <= CTL_NORM;
          end
        end
        CTL_NORM: begin
          if (commit) begin
            if (touch_next[0]) begin
              data_input_value_reg <= sh_data_next;
              mod_load <= 1'b1;
            end
            if (touch_next[2])
              offset_calibration_reg <= sh_ocal_next;
            if (touch_next[3])
              full_scale_calibration_reg <= sh_fcal_next;
            if (touch_next[1]) begin
              command_control_reg <= cmd_new;
              if (cmd_new[`CMD_CALIBRATION_RESET]) begin
                offset_calibration_reg <= `CAL_RESET;
                full_scale_calibration_reg <= `CAL_RESET;
              end
              if (mode_new == `MODE_SELFCAL) begin
                cal_cnt_reg <= 32'h0;
                ctl_reg <= CTL_CAL;
              end
            end
          end
          if (command_control_reg[`CMD_CLR])
            data_input_value_reg <= `DATA_RESET;
        end
        default: ctl_reg <= CTL_POR;
      endcase
    end
  end

  // ------------------------------------------------------------
  // modulator and analog controls
  // ------------------------------------------------------------
  wire [23:0] code_bin = data_input_value_reg ^
                         {~command_control_reg[`CMD_DF], 23'h000000};

  // outputs registered; the 40 mV step test is analog and left to it
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mod_code <= 20'h00000;
      res_20bit <= 1'b0;
      fast_settle_adaptive <= 1'b0;
      fast_settle_forced <= 1'b0;
      sh_connect <= 1'b0;
      output_enable <= 1'b0;
      cal_active <= 1'b0;
      sleep_active <= 1'b1;
    end else begin
      res_20bit <= command_control_reg[`CMD_RES];
      mod_code <= command_control_reg[`CMD_RES] ? code_bin[23:4] : {code_bin[23:8], 4'h0};
      fast_settle_adaptive <= ~command_control_reg[`CMD_FAST_SETTLE_DISABLE] & ~command_control_reg[`CMD_ADAPTIVE_FILTER_DISABLE];
      fast_settle_forced <= ~command_control_reg[`CMD_FAST_SETTLE_DISABLE] & command_control_reg[`CMD_ADAPTIVE_FILTER_DISABLE];
      sh_connect <= command_control_reg[`CMD_SH];
      cal_active <= (ctl_reg == CTL_CAL);
      sleep_active <= (ctl_reg == CTL_POR) || (op_mode == `MODE_SLEEP);
      if (ctl_reg == CTL_CAL)
        output_enable <= command_control_reg[`CMD_CAL_OUTPUT_CONNECT];
      else
        output_enable <= (ctl_reg == CTL_NORM) && (op_mode == `MODE_NORMAL);
    end
  end

endmodule

/* bench/dac_serial_props.sv */
`timescale 1ns/10ps
// --------------------------------
// port-level checker
// --------------------------------
module dac_serial_props #(
  parameter [31:0] IDLE_CYCLES = 32'd300,
  parameter [31:0] CAL_CYCLES = 32'd800
) (
  input wire clk,
  input wire nrst,
  input wire sclk,
  input wire cs_n,
  input wire sdio_in,
  input wire sdio_out,
  input wire sdio_oe,
  input wire [23:0] cal_offset_result,
  input wire [23:0] cal_gain_result,
  input wire [19:0] mod_code,
  input wire mod_load,
  input wire res_20bit,
  input wire fast_settle_adaptive,
  input wire fast_settle_forced,
  input wire sh_connect,
  input wire output_enable,
  input wire cal_active,
  input wire sleep_active,
  input wire iface_timeout
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // calibration must hold a while, then end inside the window
  sequence cal_hold;
    cal_active [*8];
  endsequence
  AST_CAL_LEN: assert property ($rose(cal_active) |-> cal_hold ##[1:1000] !cal_active)
    else $error("calibration length out of range");
  AST_OE_SCLK: assert property ($rose(sdio_oe) |-> !$past(sclk, 2))
    else $error("read drive began away from a falling sclk");
  AST_OUT_HOLD: assert property (sdio_oe && $past(sdio_oe) && $changed(sdio_out) |-> $past(sclk, 2))
    else $error("read bit moved outside a high sclk phase");
  AST_RST_SLEEP: assert property ($rose(nrst) |-> sleep_active && !output_enable && !cal_active)
    else $error("reset did not leave the device asleep");
  AST_FAST_EXCL: assert property (!(fast_settle_adaptive && fast_settle_forced))
    else $error("both settling modes active");
  AST_SLEEP_OFF: assert property (sleep_active |-> !output_enable)
    else $error("output on while asleep");
  AST_CAL_NOT_SLEEP: assert property (cal_active |-> !sleep_active)
    else $error("calibrating and asleep at once");
  AST_LOAD_PULSE: assert property (mod_load |=> !mod_load)
    else $error("modulator load longer than one cycle");
  AST_TOUT_PULSE: assert property (iface_timeout |=> !iface_timeout)
    else $error("idle recovery pulse too long");
endmodule

bind dac_serial_register_control dac_serial_props #(
  .IDLE_CYCLES(IDLE_CYCLES), .CAL_CYCLES(CAL_CYCLES)) i_props (
  .clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
  .sdio_out(sdio_out), .sdio_oe(sdio_oe), .cal_offset_result(cal_offset_result),
  .cal_gain_result(cal_gain_result), .mod_code(mod_code), .mod_load(mod_load),
  .res_20bit(res_20bit), .fast_settle_adaptive(fast_settle_adaptive),
  .fast_settle_forced(fast_settle_forced), .sh_connect(sh_connect),
  .output_enable(output_enable), .cal_active(cal_active),
  .sleep_active(sleep_active), .iface_timeout(iface_timeout));

/* bench/host_model.sv */
`timescale 1ns/10ps
// --------------------------------
// serial host on the far side
// --------------------------------
module host_model #(
  parameter real HALF = 62.5
) (
  output logic sclk,
  output logic cs_n,
  output wire sdio_in,
  input wire sdio_out,
  input wire sdio_oe
);
  logic d = 1'b0;
  logic drv = 1'b0;
  logic lsb = 1'b0;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end
  // released wire shows the inverse of the last bit, never a stale copy
  assign sdio_in = sdio_oe ? sdio_out : (drv ? d : ~d);
  // frame edges; sclk stands low between frames
  task automatic frame(input logic v);
    #(HALF) cs_n = v;
    drv = 1'b0;
    #(HALF);
  endtask
  // one byte; data changes with the rising sclk, sampled before the fall
  task automatic shift(input logic [7:0] wb, input logic rd, output logic [7:0] rb);
    int i;
    int k;
    for (i = 0; i < 8; i++) begin
      k = lsb ? i : 7 - i;
      sclk = 1'b1;
      drv = !rd;
      if (!rd) d = wb[k];
      #(HALF);
      rb[k] = sdio_in;
      sclk = 1'b0;
      #(HALF);
    end
  endtask
endmodule

/* bench/tb_top.sv */
`timescale 1ns/10ps
`include "dac_serial_defines.vh"
module tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  wire sclk, cs_n, sdio_in, sdio_out, sdio_oe, mod_load, res_20bit, fsa, fsf;
  wire sh_connect, output_enable, cal_active, sleep_active, iface_timeout;
  wire [19:0] mod_code;
  int fails = 0;
  int cmp_count = 0;
  int loads = 0;
  int touts = 0;
  int k;
  logic [31:0] lfsr = 32'h42df;
  // calibration results follow the random source so the capture is exercised
  wire [23:0] cal_off = lfsr[23:0];
  wire [23:0] cal_gain = lfsr[31:8];
  logic [23:0] m_data = 24'h0, m_ocal = 24'h0, m_fcal = 24'h0;
  logic [15:0] m_cmd = `CMD_RESET;
  initial forever #2 clk = ~clk;
  dac_serial_register_control #(.IDLE_CYCLES(32'd300), .CAL_CYCLES(32'd800)) i_dut (
    .clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .cal_offset_result(cal_off),
    .cal_gain_result(cal_gain), .mod_code(mod_code), .mod_load(mod_load),
    .res_20bit(res_20bit), .fast_settle_adaptive(fsa), .fast_settle_forced(fsf),
    .sh_connect(sh_connect), .output_enable(output_enable), .cal_active(cal_active),
    .sleep_active(sleep_active), .iface_timeout(iface_timeout));
  host_model i_host (.sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe));
  // count one-cycle pulses
  always @(posedge clk) begin
    if (mod_load === 1'b1) loads++;
    if (iface_timeout === 1'b1) touts++;
  end
  function automatic [31:0] rnd(input [31:0] s);
    rnd = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  // model byte read; reserved holes read zero
  function automatic [7:0] mrd(input [3:0] p);
    mrd = 8'h0;
    if (p[1:0] != 2'h3 && p[3:1] != 3'b011) case (p[3:2])
      2'h0: mrd = m_data[8*(2-p[1:0]) +: 8];
      2'h1: mrd = m_cmd[8*(1-p[0]) +: 8];
      2'h2: mrd = m_ocal[8*(2-p[1:0]) +: 8];
      default: mrd = m_fcal[8*(2-p[1:0]) +: 8];
    endcase
  endfunction
  task automatic outs;
    logic [1:0] md;
    logic [23:0] cb;
    md = m_cmd[1:0];
    // offset two's complement flips the top bit into straight binary
    cb = m_data ^ {~m_cmd[5], 23'h0};
    chk("code", m_cmd[7] ? {4'h0, cb[23:4]} : {4'h0, cb[23:8], 4'h0}, mod_code);
    chk("sleep", md == 2'h2, sleep_active);
    chk("out_en", md == 2'h0 || (md == 2'h1 && m_cmd[14]), output_enable);
    chk("res", m_cmd[7], res_20bit);
    chk("sh", m_cmd[13], sh_connect);
    chk("fast_a", !m_cmd[4] && !m_cmd[15], fsa);
    chk("fast_f", !m_cmd[4] && m_cmd[15], fsf);
  endtask
  // one full transaction; n is the length code, never 11
  task automatic xact(input logic rd, input logic [1:0] n, input logic [3:0] a,
      input logic [23:0] wv);
    logic [7:0] rb, wb;
    logic [3:0] p;
    logic [23:0] pd, po, pf;
    logic [15:0] pc;
    logic dn, cw, blk;
    int i;
    pd = m_data;
    po = m_ocal;
    pf = m_fcal;
    pc = m_cmd;
    cw = 1'b0;
    p = a;
    blk = m_cmd[1:0] == 2'h1;
    dn = m_cmd[3] && !(!rd && a[3:2] == 2'h1);
    i_host.frame(1'b0);
    i_host.shift({rd, n, 1'b0, a}, 1'b0, rb);
    for (i = 0; i <= n; i++) begin
      wb = wv[8*(n-i) +: 8];
      i_host.shift(wb, rd, rb);
      if (rd) chk("rd_byte", mrd(p), rb);
      else if (p[1:0] != 2'h3 && p[3:1] != 3'b011) case (p[3:2])
        2'h0: pd[8*(2-p[1:0]) +: 8] = wb;
        2'h1: begin
          pc[8*(1-p[0]) +: 8] = wb;
          cw = 1'b1;
        end
        2'h2: po[8*(2-p[1:0]) +: 8] = wb;
        default: pf[8*(2-p[1:0]) +: 8] = wb;
      endcase
      p = dn ? p - 4'h1 : p + 4'h1;
    end
    i_host.frame(1'b1);
    repeat (20) @(posedge clk);
    #1;
    if (!rd && !blk) begin
      m_data = pd;
      m_ocal = po;
      m_fcal = pf;
      m_cmd = (pc & ~`CMD_FIX_MASK) | `CMD_FIX_VAL;
      if (cw && m_cmd[9]) {m_ocal, m_fcal} = 48'h0;
    end
    if (m_cmd[6]) m_data = 24'h0;
    i_host.lsb = m_cmd[2];
    outs();
  endtask
  task automatic close_out;
    $display("counts: %0d compares, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // watchdog sized well past the expected run
  initial begin
    #390000;
    fails++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    xact(1'b1, 2'h1, 4'h4, 24'h0);
    $display("test reset done");
    k = loads;
    for (int j = 0; j < 3; j++) begin
      lfsr = rnd(lfsr);
      xact(1'b0, 2'h2, 4'((j == 0) ? 0 : 4 + 4 * j), lfsr[23:0]);
      xact(1'b1, 2'h2, 4'((j == 0) ? 0 : 4 + 4 * j), 24'h0);
    end
    chk("load", 1, loads - k);
    xact(1'b0, 2'h0, 4'h7, 24'hff);
    xact(1'b1, 2'h0, 4'h7, 24'h0);
    $display("test round trip done");
    for (int j = 0; j < 4; j++) xact(1'b0, 2'h1, 4'h4, {8'h0, j[0], 1'b0, j[1], 5'h8, j[0],
      2'h0, j[1], 4'h0});
    $display("test settling done");
    xact(1'b0, 2'h1, 4'h4, 24'h2808);
    lfsr = rnd(lfsr);
    xact(1'b0, 2'h2, 4'h2, lfsr[23:0]);
    xact(1'b1, 2'h2, 4'h2, 24'h0);
    xact(1'b1, 2'h1, 4'h4, 24'h0);
    xact(1'b0, 2'h1, 4'h4, 24'h280c);
    xact(1'b1, 2'h2, 4'h2, 24'h0);
    xact(1'b0, 2'h1, 4'h4, 24'h2800);
    $display("test ordering done");
    xact(1'b0, 2'h1, 4'h4, 24'h2860);
    chk("clr_bin", 24'h0, mod_code);
    xact(1'b0, 2'h1, 4'h4, 24'h2840);
    chk("clr_otc", 24'h80000, mod_code);
    xact(1'b0, 2'h1, 4'h4, 24'h2800);
    xact(1'b0, 2'h2, 4'h0, 24'hffffff);
    chk("low16", 24'h0, mod_code[3:0]);
    $display("test clear done");
    lfsr = rnd(lfsr);
    xact(1'b0, 2'h1, 4'h4, 24'h6801);
    chk("cal_on", 1, cal_active);
    xact(1'b0, 2'h0, 4'h0, 24'h55);
    for (k = 0; k < 2000 && cal_active !== 1'b0; k++) @(posedge clk);
    #1;
    chk("cal_end", 0, cal_active);
    m_cmd[1:0] = 2'h0;
    m_ocal = cal_off;
    m_fcal = cal_gain;
    xact(1'b1, 2'h1, 4'h4, 24'h0);
    xact(1'b1, 2'h2, 4'h8, 24'h0);
    xact(1'b1, 2'h2, 4'hc, 24'h0);
    xact(1'b1, 2'h2, 4'h0, 24'h0);
    xact(1'b0, 2'h1, 4'h4, 24'h2a00);
    xact(1'b1, 2'h2, 4'h8, 24'h0);
    xact(1'b1, 2'h2, 4'hc, 24'h0);
    $display("test calibration done");
    k = touts;
    i_host.frame(1'b0);
    i_host.shift(8'h40, 1'b0, lfsr[7:0]);
    repeat (400) @(posedge clk);
    i_host.frame(1'b1);
    chk("timeout", 1, touts - k);
    xact(1'b1, 2'h2, 4'h0, 24'h0);
    $display("test idle recovery done");
    close_out();
  end
endmodule
